//--- design/ctxpc_pkg.sv
// constants for the transmit port control block
package ctxpc_pkg;
  localparam logic [7:0] CTXPC_ADDR_PORT_SEL = 8'h32;
  localparam logic [7:0] CTXPC_ADDR_CTL = 8'h33;
  localparam logic [7:0] CTXPC_ADDR_CTL_TWO = 8'h34;
  localparam logic [7:0] CTXPC_ADDR_STATUS = 8'h35;
  localparam logic [7:0] CTXPC_RST_PORT_SEL = 8'h00;
  localparam logic [7:0] CTXPC_RST_CTL = 8'h00;
  localparam logic [7:0] CTXPC_RST_CTL_TWO = 8'h00;
  localparam logic [7:0] CTXPC_PORT_SEL_MASK = 8'h13;
  localparam int CTXPC_SEL_RD_BIT = 4;
  localparam int CTXPC_SEL_WR0_BIT = 0;
  localparam int CTXPC_SEL_WR1_BIT = 1;
  // tx_port_control fields
  localparam int CTXPC_CTL_CAL_EN = 6;
  localparam int CTXPC_CTL_LANE_LO = 4;
  localparam int CTXPC_CTL_LP00_LO = 2;
  localparam int CTXPC_CTL_CONT_CLK = 1;
  localparam int CTXPC_CTL_ENABLE = 0;
  localparam logic [7:0] CTXPC_CTL_MASK = 8'h7F;
  // tx_port_control_two fields
  localparam int CTXPC_CTL2_PASS_MODE = 3;
  localparam int CTXPC_CTL2_INVERT = 2;
  localparam int CTXPC_CTL2_SINGLE = 1;
  localparam logic [7:0] CTXPC_CTL2_MASK = 8'h0E;
  // lp00 force codes
  localparam logic [1:0] CTXPC_LP00_NORMAL = 2'h0;
  localparam logic [1:0] CTXPC_LP00_DATA = 2'h1;
  localparam logic [1:0] CTXPC_LP00_ALL = 2'h3;
  // deskew sequence length in bits and bytes
  localparam int CTXPC_DESKEW_BITS = 1024;
  localparam int CTXPC_DESKEW_BYTES = CTXPC_DESKEW_BITS / 8;
  localparam logic [7:0] CTXPC_DESKEW_PATTERN = 8'h55;
  localparam int CTXPC_NUM_PORTS = 2;
  localparam int CTXPC_NUM_LANES = 4;
endpackage

//--- design/ctxpc_cross_if.sv
// control and handshake signals between register and link domains
`timescale 1ns/1ns
`default_nettype none
interface ctxpc_cross_if;
  logic enable;
  logic cal_en;
  logic cont_clk;
  logic [1:0] lp00;
  logic [3:0] lane_mask;
  logic invert;
  logic single_tgl;
  logic done_tgl;
  modport ctrl (output enable, cal_en, cont_clk, lp00, lane_mask, invert,
    single_tgl, input done_tgl);
  modport link (input enable, cal_en, cont_clk, lp00, lane_mask, invert,
    single_tgl, output done_tgl);
endinterface
`default_nettype wire

//--- design/ctxpc_link.sv
// link-clock side lane sequencer with two-entry word buffer
`timescale 1ns/1ns
`default_nettype none
module ctxpc_link
  import ctxpc_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  // link clock and reset
  input wire logic lclk_i,
  input wire logic lrst_i,
  // crossing
  ctxpc_cross_if.link cx,
  // stream input
  input wire logic [DATA_W-1:0] s_data_i,
  input wire logic s_valid_i,
  input wire logic s_last_i,
  output logic s_ready_o,
  // lane output
  output logic [DATA_W-1:0] lane_data_o,
  output logic lane_hs_o,
  output logic lane_deskew_o,
  output logic [3:0] lane_lp00_o,
  output logic clk_lp00_o,
  output logic clk_cont_o,
  output logic [3:0] lane_active_o,
  input wire logic lane_ready_i
);
  typedef enum {LK_OFF, LK_INIT_CAL, LK_IDLE, LK_PKT, LK_CAL} ctxpc_lk_e;
  typedef struct packed {
    logic [6:0] cfg_s1;
    logic [6:0] cfg_s2;
    logic [2:0] tgl_s;
    logic [3:0] lane_s1;
    logic [3:0] lane_s2;
    logic single_pend;
    logic done_tgl;
    ctxpc_lk_e st;
    logic [7:0] cnt;
    logic sent_pkt;
    logic [1:0][DATA_W:0] buf_d;
    logic [1:0] buf_v;
    logic wp;
    logic rp;
    logic [DATA_W-1:0] out_d;
    logic out_hs;
    logic out_cal;
  } ctxpc_lk_s;
  ctxpc_lk_s r, nxt;
  logic en_s, cal_en_s, cont_s, inv_s;
  logic [1:0] lp_s;
  logic buf_full, buf_empty, pop, lp_ok;
  logic [DATA_W:0] head;
  assign {en_s, cal_en_s, cont_s, inv_s, lp_s} = r.cfg_s2[5:0];
  assign buf_full = &r.buf_v;
  assign buf_empty = ~|r.buf_v;
  assign head = r.buf_d[r.rp];
  assign s_ready_o = ~buf_full;
  assign cx.done_tgl = r.done_tgl;
  // reserved code behaves as normal
  assign lp_ok = (lp_s == CTXPC_LP00_NORMAL) || (lp_s == 2'h2); // [RULE_15]
  assign pop = (r.st == LK_PKT || r.st == LK_IDLE) && !buf_empty &&
    lane_ready_i && lp_ok;

  always_comb
  begin
    nxt = r;
    nxt.cfg_s1 = {1'b0, cx.enable, cx.cal_en, cx.cont_clk, cx.invert,
      cx.lp00};
    nxt.cfg_s2 = r.cfg_s1;
    nxt.tgl_s = {r.tgl_s[1:0], cx.single_tgl};
    nxt.lane_s1 = cx.lane_mask;
    nxt.lane_s2 = r.lane_s1;
    if (r.tgl_s[2] ^ r.tgl_s[1])
    begin
      nxt.single_pend = 1'b1;
    end
    if (s_valid_i && !buf_full)
    begin
      nxt.buf_d[r.wp] = {s_last_i, s_data_i};
      nxt.buf_v[r.wp] = 1'b1;
      nxt.wp = ~r.wp;
    end
    nxt.out_hs = 1'b0;
    nxt.out_cal = 1'b0;
    if (pop)
    begin
      nxt.buf_v[r.rp] = 1'b0;
      nxt.rp = ~r.rp;
      nxt.out_d = head[DATA_W-1:0];
      nxt.out_hs = 1'b1;
      nxt.sent_pkt = 1'b1; // [RULE_05]
    end
    case (r.st)
      LK_OFF:
      begin
        nxt.sent_pkt = 1'b0;
        if (en_s) // [RULE_06]
        begin
          nxt.cnt = 8'h00;
          nxt.st = cal_en_s ? LK_INIT_CAL : LK_IDLE; // [RULE_01]
        end
      end
      LK_INIT_CAL, LK_CAL:
      begin
        if (lane_ready_i)
        begin
          nxt.out_cal = 1'b1;
          nxt.out_d = {(DATA_W/8){inv_s ? ~CTXPC_DESKEW_PATTERN :
            CTXPC_DESKEW_PATTERN}}; // [RULE_09]
          nxt.cnt = r.cnt + 8'h01;
          if (r.cnt == 8'(CTXPC_DESKEW_BYTES - 1)) // [RULE_10]
          begin
            nxt.st = LK_IDLE;
            if (r.st == LK_CAL)
            begin
              // a request landing on the last word is kept
              nxt.single_pend = r.tgl_s[2] ^ r.tgl_s[1];
              nxt.done_tgl = ~r.done_tgl; // [RULE_12]
            end
          end
        end
      end
      LK_IDLE:
      begin
        if (!en_s)
        begin
          nxt.st = LK_OFF;
        end
        else if (pop && !head[DATA_W])
        begin
          nxt.st = LK_PKT;
        end
        else if (r.single_pend && !pop)
        begin
          nxt.cnt = 8'h00;
          nxt.st = LK_CAL; // [RULE_11]
        end
      end
      LK_PKT:
      begin
        if (pop && head[DATA_W])
        begin
          nxt.st = LK_IDLE;
        end
      end
      default:
      begin
        nxt.st = LK_OFF;
      end
    endcase
  end

  always_ff @(posedge lclk_i)
  begin
    if (lrst_i)
    begin
      r <= '0;
      r.st <= LK_OFF;
    end
    else
    begin
      r <= nxt;
    end
  end

  assign lane_data_o = r.out_d;
  assign lane_hs_o = r.out_hs;
  assign lane_deskew_o = r.out_cal;
  assign lane_active_o = en_s ? r.lane_s2 : 4'h0;
  assign lane_lp00_o = (lp_s == CTXPC_LP00_DATA || lp_s == CTXPC_LP00_ALL) ?
    4'hF : 4'h0; // [RULE_04]
  assign clk_lp00_o = (lp_s == CTXPC_LP00_ALL); // [RULE_04]
  assign clk_cont_o = cont_s && r.sent_pkt && en_s; // [RULE_05]
endmodule
`default_nettype wire

//--- design/ctxpc_top.sv
// paged register file for two transmit ports with link sequencers
// Functional notes
// (RULE_01) initial deskew enabled sends calibration before any hs data.
// (RULE_02) software should set initial deskew for 1.6 Gbps lane rate.
// (RULE_03) lane count 00/01/10/11 gives four/three/two/one lanes.
// (RULE_04) lp00 force 00 normal, 01 data lanes, 11 data and clock.
// (RULE_05) continuous clock starts only after the first packet is sent; the code starts it with the first hs word of that packet.
// (RULE_06) output enable gates the transmit output and resets off.
// (RULE_07) software disables forwarding before toggling output enable.
// (RULE_08) pass mode 0 needs any enabled port valid, 1 needs all.
// (RULE_09) deskew pattern is 01010101, inverted to 10101010 on request.
// (RULE_10) a single deskew request sends exactly one 1024-bit sequence.
// (RULE_11) single deskew waits for idle and never splits a packet.
// (RULE_12) single deskew bit clears itself after the sequence is sent.
// (RULE_13) registers exist per port and page select picks the copy.
// (RULE_14) reads use select bit 4, writes use select bits 0 and 1.
// (RULE_15) reserved lp00 code 10 acts as normal operation.
`timescale 1ns/1ns
`default_nettype none
module ctxpc_top
  import ctxpc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int NUM_RX = 4
)
(
  // system clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // receive port video status
  input wire logic [NUM_RX-1:0] rx_enabled_i,
  input wire logic [NUM_RX-1:0] rx_valid_i,
  // link clock and reset
  input wire logic lclk_i,
  input wire logic lrst_i,
  // per port streams
  input wire logic [CTXPC_NUM_PORTS-1:0][DATA_W-1:0] s_data_i,
  input wire logic [CTXPC_NUM_PORTS-1:0] s_valid_i,
  input wire logic [CTXPC_NUM_PORTS-1:0] s_last_i,
  output logic [CTXPC_NUM_PORTS-1:0] s_ready_o,
  // per port lanes
  output logic [CTXPC_NUM_PORTS-1:0][DATA_W-1:0] lane_data_o,
  output logic [CTXPC_NUM_PORTS-1:0] lane_hs_o,
  output logic [CTXPC_NUM_PORTS-1:0] lane_deskew_o,
  output logic [CTXPC_NUM_PORTS-1:0][3:0] lane_lp00_o,
  output logic [CTXPC_NUM_PORTS-1:0] clk_lp00_o,
  output logic [CTXPC_NUM_PORTS-1:0] clk_cont_o,
  output logic [CTXPC_NUM_PORTS-1:0][3:0] lane_active_o,
  input wire logic [CTXPC_NUM_PORTS-1:0] lane_ready_i,
  // pass indication
  output logic [CTXPC_NUM_PORTS-1:0] tx_pass_o
);
  typedef struct packed {
    logic [7:0] port_sel;
    logic [CTXPC_NUM_PORTS-1:0][7:0] ctl;
    logic [CTXPC_NUM_PORTS-1:0][7:0] ctl2;
    logic [CTXPC_NUM_PORTS-1:0] single_tgl;
    logic [CTXPC_NUM_PORTS-1:0][2:0] done_s;
    logic [NUM_RX-1:0] en_s1, en_s2, val_s1, val_s2;
    logic [CTXPC_NUM_PORTS-1:0] pass;
    logic [7:0] rdata;
  } ctxpc_top_s;
  ctxpc_top_s r, nxt;
  logic [CTXPC_NUM_PORTS-1:0] done_tgl;
  logic rd_port;
  logic any_ok, all_ok;

  assign rd_port = r.port_sel[CTXPC_SEL_RD_BIT]; // [RULE_14]
  assign any_ok = |(r.en_s2 & r.val_s2);
  assign all_ok = (|r.en_s2) && ((r.en_s2 & r.val_s2) == r.en_s2);

  always_comb
  begin
    nxt = r;
    nxt.en_s1 = rx_enabled_i;
    nxt.en_s2 = r.en_s1;
    nxt.val_s1 = rx_valid_i;
    nxt.val_s2 = r.val_s1;
    for (int p = 0; p < CTXPC_NUM_PORTS; p++)
    begin
      nxt.done_s[p] = {r.done_s[p][1:0], done_tgl[p]};
      // pass policy chosen per port
      nxt.pass[p] = r.ctl2[p][CTXPC_CTL2_PASS_MODE] ?
        all_ok : any_ok; // [RULE_08]
    end
    if (reg_wr_i)
    begin
      if (reg_addr_i == CTXPC_ADDR_PORT_SEL)
      begin
        nxt.port_sel = reg_wdata_i & CTXPC_PORT_SEL_MASK;
      end
      for (int p = 0; p < CTXPC_NUM_PORTS; p++)
      begin
        // write broadcast to each port whose write bit is set
        if (r.port_sel[CTXPC_SEL_WR0_BIT + p]) // [RULE_13] [RULE_14]
        begin
          if (reg_addr_i == CTXPC_ADDR_CTL)
          begin
            nxt.ctl[p] = reg_wdata_i & CTXPC_CTL_MASK;
          end
          if (reg_addr_i == CTXPC_ADDR_CTL_TWO)
          begin
            nxt.ctl2[p] = reg_wdata_i & CTXPC_CTL2_MASK;
            if (reg_wdata_i[CTXPC_CTL2_SINGLE] &&
              !r.ctl2[p][CTXPC_CTL2_SINGLE])
            begin
              nxt.single_tgl[p] = ~r.single_tgl[p]; // [RULE_10]
            end
            else if (r.ctl2[p][CTXPC_CTL2_SINGLE])
            begin
              // request already pending stays pending
              nxt.ctl2[p][CTXPC_CTL2_SINGLE] = 1'b1;
            end
          end
        end
      end
    end
    for (int p = 0; p < CTXPC_NUM_PORTS; p++)
    begin
      // completion clears unless a new request toggles in same cycle
      if ((r.done_s[p][2] ^ r.done_s[p][1]) &&
        (nxt.single_tgl[p] == r.single_tgl[p]))
      begin
        nxt.ctl2[p][CTXPC_CTL2_SINGLE] = 1'b0; // [RULE_12]
      end
    end
    nxt.rdata = 8'h00;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        CTXPC_ADDR_PORT_SEL:
        begin
          nxt.rdata = r.port_sel;
        end
        CTXPC_ADDR_CTL:
        begin
          nxt.rdata = r.ctl[rd_port]; // [RULE_13]
        end
        CTXPC_ADDR_CTL_TWO:
        begin
          nxt.rdata = r.ctl2[rd_port];
        end
        CTXPC_ADDR_STATUS:
        begin
          nxt.rdata = {3'h0, rd_port, 3'h0, r.pass[rd_port]};
        end
        default:
        begin
          nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      r <= '0;
      r.port_sel <= CTXPC_RST_PORT_SEL;
      r.ctl <= {CTXPC_NUM_PORTS{CTXPC_RST_CTL}}; // [RULE_06]
      r.ctl2 <= {CTXPC_NUM_PORTS{CTXPC_RST_CTL_TWO}};
    end
    else
    begin
      r <= nxt;
    end
  end

  assign reg_rdata_o = r.rdata;
  assign tx_pass_o = r.pass;

  genvar gp;
  generate
    for (gp = 0; gp < CTXPC_NUM_PORTS; gp++)
    begin : g_port
      ctxpc_cross_if cx ();
      // quasi-static config; software changes it with forwarding off
      assign cx.enable = r.ctl[gp][CTXPC_CTL_ENABLE]; // [RULE_06]
      assign cx.cal_en = r.ctl[gp][CTXPC_CTL_CAL_EN];
      assign cx.cont_clk = r.ctl[gp][CTXPC_CTL_CONT_CLK];
      assign cx.lp00 = r.ctl[gp][CTXPC_CTL_LP00_LO +: 2];
      assign cx.invert = r.ctl2[gp][CTXPC_CTL2_INVERT];
      assign cx.single_tgl = r.single_tgl[gp];
      assign done_tgl[gp] = cx.done_tgl;
      always_comb
      begin
        case (r.ctl[gp][CTXPC_CTL_LANE_LO +: 2]) // [RULE_03]
          2'h0: cx.lane_mask = 4'hF;
          2'h1: cx.lane_mask = 4'h7;
          2'h2: cx.lane_mask = 4'h3;
          default: cx.lane_mask = 4'h1;
        endcase
      end
      ctxpc_link #(.DATA_W(DATA_W)) u_link (
        .lclk_i(lclk_i),
        .lrst_i(lrst_i),
        .cx(cx),
        .s_data_i(s_data_i[gp]),
        .s_valid_i(s_valid_i[gp]),
        .s_last_i(s_last_i[gp]),
        .s_ready_o(s_ready_o[gp]),
        .lane_data_o(lane_data_o[gp]),
        .lane_hs_o(lane_hs_o[gp]),
        .lane_deskew_o(lane_deskew_o[gp]),
        .lane_lp00_o(lane_lp00_o[gp]),
        .clk_lp00_o(clk_lp00_o[gp]),
        .clk_cont_o(clk_cont_o[gp]),
        .lane_active_o(lane_active_o[gp]),
        .lane_ready_i(lane_ready_i[gp])
      );
    end
  endgenerate
endmodule
`default_nettype wire

//--- test/ctxpc_assertions.sv
// checker on the top ports of the transmit port control block
`timescale 1ns/1ns
`default_nettype none
module ctxpc_chk
  import ctxpc_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  // register domain
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // link domain
  input wire logic lclk_i,
  input wire logic lrst_i,
  input wire logic [CTXPC_NUM_PORTS-1:0][DATA_W-1:0] lane_data_o,
  input wire logic [CTXPC_NUM_PORTS-1:0] lane_hs_o,
  input wire logic [CTXPC_NUM_PORTS-1:0] lane_deskew_o,
  input wire logic [CTXPC_NUM_PORTS-1:0][3:0] lane_lp00_o,
  input wire logic [CTXPC_NUM_PORTS-1:0] clk_lp00_o,
  input wire logic [CTXPC_NUM_PORTS-1:0] clk_cont_o,
  input wire logic [CTXPC_NUM_PORTS-1:0][3:0] lane_active_o
);
  logic seen_r;
  always_ff @(posedge lclk_i)
  begin
    if (lrst_i)
      seen_r <= 1'b0;
    else if (lane_hs_o[0])
      seen_r <= 1'b1;
  end
  a_rd_idle: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data not idle");
  a_rd_unmapped: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && !(reg_addr_i inside {[8'h32:8'h35]}) |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_cont_late: assert property (
    @(posedge lclk_i) disable iff (lrst_i)
    $rose(clk_cont_o[0]) |-> seen_r || lane_hs_o[0])
    else $error("continuous clock before first packet");
  a_dsk_pattern: assert property (
    @(posedge lclk_i) disable iff (lrst_i)
    lane_deskew_o[0] |-> lane_data_o[0][7:0] inside {8'h55, 8'hAA})
    else $error("deskew pattern wrong");
  a_lane_mask: assert property (
    @(posedge lclk_i) disable iff (lrst_i)
    lane_active_o[0] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("lane mask illegal");
  a_hs_enabled: assert property (
    @(posedge lclk_i) disable iff (lrst_i)
    lane_hs_o[0] |-> lane_active_o[0] != 4'h0) else $error("hs while off");
  a_hs_dsk_excl: assert property (
    @(posedge lclk_i) disable iff (lrst_i)
    lane_hs_o[0] |-> !lane_deskew_o[0]) else $error("deskew inside data");
  a_lp00_clk: assert property (
    @(posedge lclk_i) disable iff (lrst_i)
    clk_lp00_o[0] |-> lane_lp00_o[0] != 4'h0) else $error("clock lp00 alone");
  c_dsk: cover property (@(posedge lclk_i) lane_deskew_o[0]);
  c_hs: cover property (@(posedge lclk_i) lane_hs_o[0]);
  c_cont: cover property (@(posedge lclk_i) $rose(clk_cont_o[0]));
endmodule
bind ctxpc_top ctxpc_chk #(.DATA_W(DATA_W)) u_chk (
  .mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .lclk_i(lclk_i),
  .lrst_i(lrst_i), .lane_data_o(lane_data_o), .lane_hs_o(lane_hs_o),
  .lane_deskew_o(lane_deskew_o), .lane_lp00_o(lane_lp00_o),
  .clk_lp00_o(clk_lp00_o), .clk_cont_o(clk_cont_o),
  .lane_active_o(lane_active_o));
`default_nettype wire

//--- test/ctxpc_sink.sv
// downstream receiver model for the lanes of one transmit port
`timescale 1ns/1ns
`default_nettype none
module ctxpc_sink (
  // link side
  input wire logic lclk_i,
  input wire logic stall_i,
  input wire logic hs_i,
  input wire logic dsk_i,
  input wire logic [31:0] data_i,
  output logic ready_o
);
  int hs_cnt = 0;
  int dsk_cnt = 0;
  int dsk_at_hs = 0;
  logic [31:0] hs_word = 32'h0;
  logic [31:0] dsk_word = 32'h0;
  logic [1:0] ph = 2'h0;
  // slow mode refuses half the cycles, like a busy receiver
  always @(posedge lclk_i)
  begin
    ph <= ph + 2'h1;
    ready_o <= !(stall_i && ph[1]);
    if (hs_i)
    begin
      hs_cnt <= hs_cnt + 1;
      hs_word <= data_i;
      dsk_at_hs <= dsk_cnt;
    end
    if (dsk_i)
    begin
      dsk_cnt <= dsk_cnt + 1;
      dsk_word <= data_i;
    end
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the transmit port control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ctxpc_pkg::*;
  logic mclk_i = 1'b0;
  logic lclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic lrst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] rx_en = 4'h0;
  logic [3:0] rx_val = 4'h0;
  logic [1:0][31:0] sd = '0;
  logic [1:0] sv = 2'h0;
  logic [1:0] sl = 2'h0;
  logic stall = 1'b0;
  logic rdy0;
  logic [7:0] rdata;
  logic [1:0] s_rdy, hs, dsk, clp, cont, pass;
  logic [1:0][31:0] ld;
  logic [1:0][3:0] lp, act;
  int fail_count = 0;
  int comparisons = 0;
  initial forever #50 mclk_i = ~mclk_i;
  initial
  begin
    // offset keeps link edges off every system clock edge
    #4;
    forever
    begin
      #7 lclk_i = 1'b1;
      #8 lclk_i = 1'b0;
    end
  end
  ctxpc_top DUT (.mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .rx_enabled_i(rx_en), .rx_valid_i(rx_val), .lclk_i(lclk_i),
    .lrst_i(lrst_i), .s_data_i(sd), .s_valid_i(sv), .s_last_i(sl),
    .s_ready_o(s_rdy), .lane_data_o(ld), .lane_hs_o(hs),
    .lane_deskew_o(dsk), .lane_lp00_o(lp), .clk_lp00_o(clp),
    .clk_cont_o(cont), .lane_active_o(act), .lane_ready_i({1'b1, rdy0}),
    .tx_pass_o(pass));
  ctxpc_sink u_sink (.lclk_i(lclk_i), .stall_i(stall), .hs_i(hs[0]),
    .dsk_i(dsk[0]), .data_i(ld[0]), .ready_o(rdy0));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(negedge mclk_i);
    d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rreg(a, v);
    chk(32'(v), 32'(e));
  endtask
  // each word is held until the edge that finds ready high
  task automatic send(input int n);
    int k;
    for (int i = 0; i < n; i++)
    begin
      @(posedge lclk_i);
      sv[0] <= 1'b1;
      sd[0] <= 32'hA000_0000 + 32'(i);
      sl[0] <= (i == n - 1);
      k = 0;
      do
      begin
        @(negedge lclk_i);
        k++;
      end
      while (s_rdy[0] !== 1'b1 && k < 500);
      if (k >= 500)
        fail_count++;
    end
    @(posedge lclk_i);
    sv[0] <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    fail_count++;
    conclude();
  end
  initial
  begin
    logic [7:0] v;
    int b;
    logic [31:0] e;
    step(20);
    srst_i <= 1'b0;
    lrst_i <= 1'b0;
    rchk(8'h32, 8'h00);
    rchk(8'h33, 8'h00);
    rchk(8'h34, 8'h00);
    rchk(8'h40, 8'h00);
    chk(32'(act[0]), 32'h0);
    $display("test reset done");
    wreg(8'h32, 8'h02);
    wreg(8'h33, 8'h3C);
    wreg(8'h32, 8'h01);
    rchk(8'h33, 8'h00);
    wreg(8'h32, 8'h11);
    rchk(8'h33, 8'h3C);
    rchk(8'h35, 8'h10);
    wreg(8'h32, 8'h02);
    wreg(8'h33, 8'h00);
    wreg(8'h32, 8'h01);
    $display("test paging done");
    for (int i = 0; i < 4; i++)
    begin
      wreg(8'h33, 8'(i * 16 + 1));
      step(4);
      chk(32'(act[0]), 32'(4'hF >> i));
    end
    chk(32'(act[1]), 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h33, 8'(c * 4 + 1));
      step(4);
      e = 32'({c == 3, c[0] ? 4'hF : 4'h0});
      chk(32'({clp[0], lp[0]}), e);
    end
    $display("test lanes done");
    wreg(8'h33, 8'h00);
    step(4);
    b = u_sink.dsk_cnt;
    stall <= 1'b1;
    wreg(8'h33, 8'h43);
    step(1);
    chk(32'(cont[0]), 32'h0);
    send(3);
    for (int i = 0; i < 300 && u_sink.hs_cnt < 3; i++)
      step(1);
    chk(32'(u_sink.dsk_cnt - b), 32'd128);
    chk(32'(u_sink.dsk_at_hs - b), 32'd128);
    chk(u_sink.dsk_word, 32'h5555_5555);
    chk(u_sink.hs_word, 32'hA000_0002);
    step(4);
    chk(32'(cont[0]), 32'h1);
    $display("test initial deskew done");
    b = u_sink.dsk_cnt;
    wreg(8'h34, 8'h06);
    rchk(8'h34, 8'h06);
    v = 8'h06;
    for (int i = 0; i < 200 && v !== 8'h04; i++)
      rreg(8'h34, v);
    chk(32'(v), 32'h04);
    chk(32'(u_sink.dsk_cnt - b), 32'd128);
    chk(u_sink.dsk_word, 32'hAAAA_AAAA);
    $display("test single deskew done");
    step(1);
    rx_en <= 4'h3;
    rx_val <= 4'h1;
    step(6);
    chk(32'(pass[0]), 32'h1);
    rchk(8'h35, 8'h01);
    wreg(8'h34, 8'h08);
    step(6);
    chk(32'(pass[0]), 32'h0);
    chk(32'(pass), 32'h2);
    rx_val <= 4'h3;
    step(6);
    chk(32'(pass[0]), 32'h1);
    $display("test pass mode done");
    conclude();
  end
endmodule
`default_nettype wire
